//--- cffm_unit.sv
`timescale 1ns/1ps
// Function
// - Input undervoltage entry sets fault bit 7
// - Input overvoltage entry sets fault bit 6
// - Battery overcurrent entry sets fault bit 5
// - Battery overvoltage entry sets fault bit 4
// - Thermal shutdown entry sets fault bit 3
// - Safety timer rising edge sets bit 2
// - Driver supply fault sets fault bit 1
// - Fault flags reset to zero
// - Mask bit 7 gates one-shot ADC pulse
// - Mask bit 6 gates input current pulse
// - Mask bit 5 gates input voltage pulse
// - Mask bit 3 gates watchdog expiry pulse
// - Mask bit 1 gates CV timer pulse
// - Mask bit 0 gates charge state pulse
// - First mask zero at reset and soft reset
// - Second mask at next address, resets zero
// - Input current regulation flag, clear on read
// - Watchdog flag on rising edge, clear read
module cffm_unit (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic       reg_reset_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       input_undervoltage_i,
    input  wire logic       input_overvoltage_i,
    input  wire logic       battery_overcurrent_i,
    input  wire logic       battery_overvoltage_i,
    input  wire logic       thermal_shutdown_i,
    input  wire logic       safety_timer_expired_i,
    input  wire logic       gate_driver_supply_pin_fault_i,
    input  wire logic       adc_done_i,
    input  wire logic       adc_one_shot_i,
    input  wire logic       input_current_reg_i,
    input  wire logic       input_voltage_reg_i,
    input  wire logic       host_watchdog_status_i,
    input  wire logic       cv_timer_expired_i,
    input  wire logic [2:0] charge_state_i,
    output logic            irq_pulse_o
);

    logic [7:0] fault_lvl;
    logic [7:0] fault_rise;
    logic [7:0] fault_flags;
    logic [7:0] chg_lvl;
    logic [7:0] chg_rise;
    logic [7:0] chg_flags;
    logic [7:0] mask_a_q;
    logic [7:0] mask_b_q;
    logic [2:0] state_prev_q;
    logic       state_chg;
    logic       rd_fault;
    logic       rd_chg;

    // Address decode of read strobes that clear flags
    assign rd_fault = reg_rd_i && (reg_addr_i == cffm_pkg::CFFM_ADDR_FAULT);
    assign rd_chg   = reg_rd_i && (reg_addr_i == cffm_pkg::CFFM_ADDR_CHG_FLAG);

    assign fault_lvl = {input_undervoltage_i, input_overvoltage_i,
                        battery_overcurrent_i, battery_overvoltage_i,
                        thermal_shutdown_i, safety_timer_expired_i,
                        gate_driver_supply_pin_fault_i, 1'b0};

    // Previous charge state for change detection
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_prev_q <= 3'h0;
        else
            state_prev_q <= charge_state_i;
    end

    assign state_chg = (charge_state_i != state_prev_q);

    // ADC done counts only in one-shot mode
    assign chg_lvl = {adc_done_i & adc_one_shot_i, input_current_reg_i,
                      input_voltage_reg_i, 1'b0, host_watchdog_status_i,
                      1'b0, cv_timer_expired_i, state_chg};

    // edge sets flags, read clears them
    cffm_flag_bank #(
        .WIDTH (cffm_pkg::CFFM_DATA_W),
        .USED  (cffm_pkg::CFFM_FAULT_USED)
    ) u_fault (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .soft_clr_i (reg_reset_i),
        .rd_clr_i   (rd_fault),
        .level_i    (fault_lvl),
        .rise_o     (fault_rise),
        .flags_o    (fault_flags)
    );

    cffm_flag_bank #(
        .WIDTH (cffm_pkg::CFFM_DATA_W),
        .USED  (cffm_pkg::CFFM_CHG_USED)
    ) u_chg (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .soft_clr_i (reg_reset_i),
        .rd_clr_i   (rd_chg),
        .level_i    (chg_lvl),
        .rise_o     (chg_rise),
        .flags_o    (chg_flags)
    );

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mask_a_q <= cffm_pkg::CFFM_RST_MASK_A;
        else if (reg_reset_i)
            mask_a_q <= cffm_pkg::CFFM_RST_MASK_A;
        else if (reg_wr_i && reg_addr_i == cffm_pkg::CFFM_ADDR_MASK_A)
            mask_a_q <= reg_wdata_i & cffm_pkg::CFFM_MASK_A_WR;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mask_b_q <= cffm_pkg::CFFM_RST_MASK_B;
        else if (reg_reset_i)
            mask_b_q <= cffm_pkg::CFFM_RST_MASK_B;
        else if (reg_wr_i && reg_addr_i == cffm_pkg::CFFM_ADDR_MASK_B)
            mask_b_q <= reg_wdata_i & cffm_pkg::CFFM_MASK_B_WR;
    end

    // unmasked event gives one pulse
    // Fault mask lives elsewhere, so faults always pulse here
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_pulse_o <= 1'b0;
        else
            irq_pulse_o <= (|(chg_rise & ~mask_a_q)) | (|fault_rise);
    end

    // reserved bits read zero
    // Read data captured before the clear takes effect
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= cffm_pkg::CFFM_RDATA_NONE;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                cffm_pkg::CFFM_ADDR_CHG_FLAG: reg_rdata_o <= chg_flags;
                cffm_pkg::CFFM_ADDR_FAULT:    reg_rdata_o <= fault_flags;
                cffm_pkg::CFFM_ADDR_MASK_A:   reg_rdata_o <= mask_a_q;
                cffm_pkg::CFFM_ADDR_MASK_B:   reg_rdata_o <= mask_b_q;
                default:                      reg_rdata_o <= cffm_pkg::CFFM_RDATA_NONE;
            endcase
        end
    end

    // Checks on flag capture, clear and interrupt gating
    property p_uv_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(input_undervoltage_i) |=> fault_flags[7];
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("uv flag missed");

    property p_ov_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(input_overvoltage_i) |=> fault_flags[6];
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("ov flag missed");

    property p_oc_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(battery_overcurrent_i) |=> fault_flags[5];
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("oc flag missed");

    property p_bov_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(battery_overvoltage_i) |=> fault_flags[4] && irq_pulse_o;
    endproperty
    a_bov_set: assert property (p_bov_set) else $error("bat ov missed");

    property p_thermal_shutdown_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(thermal_shutdown_i) |=> fault_flags[3];
    endproperty
    a_thermal_shutdown_set: assert property (p_thermal_shutdown_set) else $error("thermal_shutdown missed");

    property p_timer_level;
        @(posedge clock_i) disable iff (!rst_b_i)
        (rd_fault && safety_timer_expired_i && $past(safety_timer_expired_i))
            |=> !fault_flags[2];
    endproperty
    a_timer_level: assert property (p_timer_level) else $error("timer level set");

    property p_drv_set;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(gate_driver_supply_pin_fault_i) |=> fault_flags[1];
    endproperty
    a_drv_set: assert property (p_drv_set) else $error("drv flag missed");

    property p_fault_reset;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> fault_flags == cffm_pkg::CFFM_RST_FAULT;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault not zero");

    property p_adc_pass;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise[7] && !mask_a_q[7]) |=> irq_pulse_o;
    endproperty
    a_adc_pass: assert property (p_adc_pass) else $error("adc pulse lost");

    property p_iin_block;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise == 8'h40 && mask_a_q[6] && fault_rise == 8'h00) |=> !irq_pulse_o;
    endproperty
    a_iin_block: assert property (p_iin_block) else $error("iin not masked");

    property p_vin_pass;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise[5] && !mask_a_q[5]) |=> irq_pulse_o;
    endproperty
    a_vin_pass: assert property (p_vin_pass) else $error("vin pulse lost");

    property p_wd_pass;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise[3] && !mask_a_q[3]) |=> irq_pulse_o;
    endproperty
    a_wd_pass: assert property (p_wd_pass) else $error("wd pulse lost");

    property p_cv_pass;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise[1] && !mask_a_q[1]) |=> irq_pulse_o;
    endproperty
    a_cv_pass: assert property (p_cv_pass) else $error("cv pulse lost");

    property p_state_pass;
        @(posedge clock_i) disable iff (!rst_b_i)
        (charge_state_i != $past(charge_state_i) && !mask_a_q[0]) ##1 1'b1
            |-> irq_pulse_o || $past(state_chg, 2);
    endproperty
    a_state_pass: assert property (p_state_pass) else $error("state pulse lost");

    property p_mask_soft;
        @(posedge clock_i) disable iff (!rst_b_i)
        reg_reset_i |=> mask_a_q == cffm_pkg::CFFM_RST_MASK_A
                        && mask_b_q == cffm_pkg::CFFM_RST_MASK_B;
    endproperty
    a_mask_soft: assert property (p_mask_soft) else $error("mask not cleared");

    property p_mask_b_wr;
        @(posedge clock_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == cffm_pkg::CFFM_ADDR_MASK_B && !reg_reset_i)
            |=> mask_b_q == ($past(reg_wdata_i) & cffm_pkg::CFFM_MASK_B_WR);
    endproperty
    a_mask_b_wr: assert property (p_mask_b_wr) else $error("mask b write");

    property p_iin_clr;
        @(posedge clock_i) disable iff (!rst_b_i)
        (rd_chg && !chg_rise[6] && !reg_reset_i) |=> !chg_flags[6];
    endproperty
    a_iin_clr: assert property (p_iin_clr) else $error("iin not cleared");

    property p_wd_flag;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(host_watchdog_status_i) |=> chg_flags[3];
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("wd flag missed");

    property p_mask_keeps_flag;
        @(posedge clock_i) disable iff (!rst_b_i)
        (chg_rise[6] && mask_a_q[6]) |=> chg_flags[6] && fault_flags[0] == 1'b0;
    endproperty
    a_mask_keeps_flag: assert property (p_mask_keeps_flag) else $error("flag blocked");

    property p_cv_fault_irq;
        @(posedge clock_i) disable iff (!rst_b_i)
        fault_rise != 8'h00 ##1 irq_pulse_o;
    endproperty
    c_fault_irq: cover property (p_cv_fault_irq);

    property p_cv_masked;
        @(posedge clock_i) disable iff (!rst_b_i)
        chg_rise[3] && mask_a_q[3] ##1 chg_flags[3];
    endproperty
    c_masked: cover property (p_cv_masked);

    property p_cv_read_clear;
        @(posedge clock_i) disable iff (!rst_b_i)
        rd_fault && fault_flags[7] ##1 !fault_flags[7];
    endproperty
    c_read_clear: cover property (p_cv_read_clear);

endmodule : cffm_unit

//--- cffm_pkg.sv
package cffm_pkg;
    // Register addresses on the serial control port
    localparam logic [7:0] CFFM_ADDR_CHG_FLAG  = 8'h25;
    localparam logic [7:0] CFFM_ADDR_FAULT     = 8'h27;
    localparam logic [7:0] CFFM_ADDR_MASK_A    = 8'h28;
    localparam logic [7:0] CFFM_ADDR_MASK_B    = 8'h29;

    // Reset values
    localparam logic [7:0] CFFM_RST_CHG_FLAG   = 8'h00;
    localparam logic [7:0] CFFM_RST_FAULT      = 8'h00;
    localparam logic [7:0] CFFM_RST_MASK_A     = 8'h00;
    localparam logic [7:0] CFFM_RST_MASK_B     = 8'h00;
    localparam logic [7:0] CFFM_RDATA_NONE     = 8'h00;

    // Implemented bits; everything else is reserved and reads zero
    localparam logic [7:0] CFFM_FAULT_USED     = 8'hFE;
    localparam logic [7:0] CFFM_CHG_USED       = 8'hEB;
    localparam logic [7:0] CFFM_MASK_A_WR      = 8'hEB;
    localparam logic [7:0] CFFM_MASK_B_WR      = 8'h9B;

    // Fault flag field positions
    localparam int CFFM_FLT_VIN_UV  = 7;
    localparam int CFFM_FLT_VIN_OV  = 6;
    localparam int CFFM_FLT_BAT_OC  = 5;
    localparam int CFFM_FLT_BAT_OV  = 4;
    localparam int CFFM_FLT_THERMAL_SHUTDOWN   = 3;
    localparam int CFFM_FLT_SAFE_TM = 2;
    localparam int CFFM_FLT_GATE_DRIVER_SUPPLY_PIN = 1;

    // Charger flag and first mask field positions
    localparam int CFFM_CHG_ADC     = 7;
    localparam int CFFM_CHG_IIN_REG = 6;
    localparam int CFFM_CHG_VIN_REG = 5;
    localparam int CFFM_CHG_WDOG    = 3;
    localparam int CFFM_CHG_CV_TM   = 1;
    localparam int CFFM_CHG_STATE   = 0;

    localparam int CFFM_DATA_W      = 8;
    localparam int CFFM_STATE_W     = 3;
endpackage : cffm_pkg

//--- cffm_flag_bank.sv
`timescale 1ns/1ps
// Bank of sticky clear-on-read flags, each set on the rising edge of its level
module cffm_flag_bank #(
    parameter int               WIDTH = 8,
    parameter logic [WIDTH-1:0] USED  = '1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             soft_clr_i,
    input  wire logic             rd_clr_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] flags_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic prev_q;
            logic flag_q;
            logic set;

            // Entry into the condition, not the level, sets the flag
            assign set = USED[g] & level_i[g] & ~prev_q;

            // Previous level for edge detection
            always_ff @(posedge clock_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    prev_q <= 1'b0;
                else
                    prev_q <= level_i[g];
            end

            // Set beats a clear in the same cycle so no event is lost
            always_ff @(posedge clock_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    flag_q <= 1'b0;
                else if (set)
                    flag_q <= 1'b1;
                else if (rd_clr_i || soft_clr_i)
                    flag_q <= 1'b0;
            end

            assign rise_o[g]  = set;
            assign flags_o[g] = flag_q;
        end
    endgenerate

endmodule : cffm_flag_bank

//--- cffm_host_model.sv
`timescale 1ns/1ps
// Host processor on the register port; strobes move on falling edges only
module cffm_host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       irq_pulse_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o
);
    int irq_seen;

    // Quiet bus at time zero; nothing is requested until the bench asks
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
        irq_seen    = 0;
    end

    // pulse tally
    // Every pulse is counted so a flag read can follow it
    always @(posedge clock_i)
    begin
        if (irq_pulse_i === 1'b1)
            irq_seen++;
    end

    // One-cycle write; address and data scrambled once the strobe drops
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(negedge clock_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask : write_reg

    // read clears
    // One-cycle read; data is taken half a cycle after the read edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock_i);
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(negedge clock_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
        data       = reg_rdata_i;
    endtask : read_reg
endmodule : cffm_host_model

//--- test_charger_fault_flag_mask_unit.sv
`timescale 1ns/1ps
// Self-checking bench for the fault flag and event mask unit
module test_charger_fault_flag_mask_unit;
    logic       clock_i;
    logic       rst_b_i;
    logic       reg_reset;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       irq_pulse;
    logic [7:0] fault_lvl;
    logic [7:0] chg_lvl;
    logic       adc_one_shot;
    logic [2:0] charge_state;
    int         failures;
    int         comparisons;

    cffm_unit dut (
        .clock_i                        (clock_i),
        .rst_b_i                        (rst_b_i),
        .reg_reset_i                    (reg_reset),
        .reg_addr_i                     (reg_addr),
        .reg_wr_i                       (reg_wr),
        .reg_rd_i                       (reg_rd),
        .reg_wdata_i                    (reg_wdata),
        .reg_rdata_o                    (reg_rdata),
        .input_undervoltage_i           (fault_lvl[7]),
        .input_overvoltage_i            (fault_lvl[6]),
        .battery_overcurrent_i          (fault_lvl[5]),
        .battery_overvoltage_i          (fault_lvl[4]),
        .thermal_shutdown_i             (fault_lvl[3]),
        .safety_timer_expired_i         (fault_lvl[2]),
        .gate_driver_supply_pin_fault_i (fault_lvl[1]),
        .adc_done_i                     (chg_lvl[7]),
        .adc_one_shot_i                 (adc_one_shot),
        .input_current_reg_i            (chg_lvl[6]),
        .input_voltage_reg_i            (chg_lvl[5]),
        .host_watchdog_status_i         (chg_lvl[3]),
        .cv_timer_expired_i             (chg_lvl[1]),
        .charge_state_i                 (charge_state),
        .irq_pulse_o                    (irq_pulse)
    );

    cffm_host_model host (
        .clock_i     (clock_i),
        .reg_rdata_i (reg_rdata),
        .irq_pulse_i (irq_pulse),
        .reg_addr_o  (reg_addr),
        .reg_wr_o    (reg_wr),
        .reg_rd_o    (reg_rd),
        .reg_wdata_o (reg_wdata)
    );

    // Free-running 125 MHz clock
    initial
        clock_i = 1'b0;
    always #4 clock_i = ~clock_i;

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
            begin
                failures++;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
    endtask : check_byte

    task automatic check_irq(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
            begin
                failures++;
                $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
            end
    endtask : check_irq

    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        host.read_reg(addr, data);
        check_byte(data, exp);
    endtask : read_check

    // Raise one event; fault levels stay held, charger levels drop one cycle later
    task automatic raise(input logic is_fault, input int b, input logic exp_irq);
        @(negedge clock_i);
        if (is_fault)
            fault_lvl[b] = 1'b1;
        else if (b == 0)
            charge_state = charge_state + 3'h1;
        else
            chg_lvl[b] = 1'b1;
        @(negedge clock_i);
        check_irq(irq_pulse, exp_irq);
        chg_lvl = 8'h00;
        @(negedge clock_i);
        check_irq(irq_pulse, 1'b0);
    endtask : raise

    // Reset values, writable bits, ignored writes, soft reset of masks
    task automatic test_regs();
        read_check(cffm_pkg::CFFM_ADDR_FAULT, 8'h00);
        read_check(cffm_pkg::CFFM_ADDR_MASK_A, 8'h00);
        read_check(cffm_pkg::CFFM_ADDR_MASK_B, 8'h00);
        host.write_reg(cffm_pkg::CFFM_ADDR_MASK_A, 8'hFF);
        read_check(cffm_pkg::CFFM_ADDR_MASK_A, 8'hEB);
        host.write_reg(cffm_pkg::CFFM_ADDR_MASK_B, 8'hFF);
        read_check(cffm_pkg::CFFM_ADDR_MASK_B, 8'h9B);
        host.write_reg(cffm_pkg::CFFM_ADDR_FAULT, 8'hFF);
        read_check(cffm_pkg::CFFM_ADDR_FAULT, 8'h00);
        read_check(8'h30, 8'h00);
        @(negedge clock_i);
        reg_reset = 1'b1;
        @(negedge clock_i);
        reg_reset = 1'b0;
        read_check(cffm_pkg::CFFM_ADDR_MASK_A, 8'h00);
        read_check(cffm_pkg::CFFM_ADDR_MASK_B, 8'h00);
    endtask : test_regs

    // Each fault pulses once and clears on read even while still held
    task automatic test_faults();
        int b;
        for (b = 7; b >= 1; b--)
            begin
                raise(1'b1, b, 1'b1);
                read_check(cffm_pkg::CFFM_ADDR_FAULT, 8'h01 << b);
                read_check(cffm_pkg::CFFM_ADDR_FAULT, 8'h00);
                fault_lvl[b] = 1'b0;
            end
    endtask : test_faults

    // Masked event latches with no pulse; unmasked event pulses
    task automatic test_masks();
        int bits[6] = '{7, 6, 5, 3, 1, 0};
        int i;
        int b;
        adc_one_shot = 1'b1;
        for (i = 0; i < 6; i++)
            begin
                b = bits[i];
                host.write_reg(cffm_pkg::CFFM_ADDR_MASK_A, 8'h01 << b);
                raise(1'b0, b, 1'b0);
                read_check(cffm_pkg::CFFM_ADDR_CHG_FLAG, 8'h01 << b);
                host.write_reg(cffm_pkg::CFFM_ADDR_MASK_A, 8'h00);
                raise(1'b0, b, 1'b1);
                read_check(cffm_pkg::CFFM_ADDR_CHG_FLAG, 8'h01 << b);
            end
        adc_one_shot = 1'b0;
        raise(1'b0, 7, 1'b0);
        read_check(cffm_pkg::CFFM_ADDR_CHG_FLAG, 8'h00);
        // Seven fault pulses plus six unmasked charger pulses, no strays
        check_byte(host.irq_seen[7:0], 8'h0D);
    endtask : test_masks

    task automatic complete_run();
        $display("TB: failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence; reset held for eight cycles, released off the edge
    initial
    begin
        failures     = 0;
        comparisons  = 0;
        rst_b_i      = 1'b0;
        reg_reset    = 1'b0;
        fault_lvl    = 8'h00;
        chg_lvl      = 8'h00;
        adc_one_shot = 1'b0;
        charge_state = 3'h0;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        rst_b_i = 1'b1;
        test_regs();
        test_faults();
        test_masks();
        complete_run();
    end

    // Watchdog well beyond the roughly 170 cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clock_i);
        failures++;
        complete_run();
    end
endmodule : test_charger_fault_flag_mask_unit
